// >>> tb/ric_cond_eval_sva.sv
// checker on the ports of the condition evaluator top
// assumes one aclk domain and the synchronous active-low aresetn
`timescale 1ns/100ps
module ric_cond_eval_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cond_result,
    input wire logic cond_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_res_act;
        cond_result |-> cond_active;
    endproperty
    a_res_act: assert property (p_res_act) else $error("result without source");
    property p_rst_out;
        $rose(aresetn) |-> !cond_result && !cond_active;
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("condition set at reset");
    // response lands exactly two edges after a joint handshake
    property p_b_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=>
            !s_axi_bvalid ##1 s_axi_bvalid;
    endproperty
    a_b_lat: assert property (p_b_lat) else $error("write response timing");
    property p_b_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_b_busy: assert property (p_b_busy) else $error("write taken while busy");
    property p_b_done;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
    endproperty
    a_b_done: assert property (p_b_done) else $error("write not released");
    property p_r_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_r_lat: assert property (p_r_lat) else $error("read data late");
    property p_r_busy;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_r_busy: assert property (p_r_busy) else $error("read taken while busy");
    property p_r_done;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    a_r_done: assert property (p_r_done) else $error("read not released");
endmodule // ric_cond_eval_chk

bind ric_cond_eval ric_cond_eval_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .cond_result, .cond_active);

// >>> tb/ric_io_model.sv
// local channel values and pin levels seen by the evaluator
// assumes callers step it from aclk; every update lands just after an edge
`timescale 1ns/100ps
module ric_io_model (
    input wire logic aclk,
    output logic [7:0][15:0] analog_value,
    output logic analog_sample,
    output logic [7:0][31:0] count_value,
    output logic [7:0][31:0] freq_value,
    output logic [7:0][31:0] counter_value,
    output logic [15:0] discrete_in_pin,
    output logic [15:0] dout_state_pin
);
    initial begin
        {analog_value, analog_sample, count_value, freq_value} = '0;
        {counter_value, discrete_in_pin, dout_state_pin} = '0;
    end
    // one strobe refreshes all channels, so other channels keep their code
    task automatic put_analog(input int ch, input logic [15:0] v);
        @(posedge aclk);
        analog_value[ch] <= v;
        analog_sample <= 1'b1;
        @(posedge aclk);
        analog_sample <= 1'b0;
    endtask
    task automatic put_val(input int s, input int ch, input logic [31:0] v);
        @(posedge aclk);
        case (s)
            3: count_value[ch] <= v;
            4: freq_value[ch] <= v;
            8: counter_value[ch] <= v;
            2: discrete_in_pin <= v[15:0];
            default: dout_state_pin <= v[15:0];
        endcase
    endtask
endmodule // ric_io_model

// >>> tb/testbench.sv
// self-checking bench: register traffic, condition sources, status reads
// assumes ric_map.svh on the include path and a shortened timer tick
`timescale 1ns/100ps
`include "ric_map.svh"
module testbench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, analog_sample, cond_result, cond_active;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0][15:0] analog_value;
    logic [7:0][31:0] count_value, freq_value, counter_value;
    logic [15:0] discrete_in_pin, dout_state_pin;
    int err_total, compares, seed, k, s, op, ch, i, sen;
    logic [31:0] v, t;
    logic e;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [1:0] cq[$];
    ric_cond_eval #(.TICK_CYCLES(21'h4)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .analog_value, .analog_sample, .count_value, .freq_value, .counter_value,
        .discrete_in_pin, .dout_state_pin, .cond_result, .cond_active);
    ric_io_model io (.aclk, .analog_value, .analog_sample, .count_value, .freq_value,
        .counter_value, .discrete_in_pin, .dout_state_pin);
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // reads against the oldest note; outputs are sampled before the edge updates
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready) chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
        if (s_axi_arvalid && s_axi_arready && s_axi_araddr == `RIC_REG_STATUS) begin
            chk({32'h0, cond_active, cond_result}, {32'h0, cq.pop_front()});
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back(r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (1) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] x);
        rq.push_back(x);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (1) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
    // status is read a few cycles on, past the pin synchronisers
    task automatic st(input logic a, input logic r);
        repeat (4) @(posedge aclk);
        cq.push_back({a, r});
        rd(`RIC_REG_STATUS, {32'h0, a, r});
    endtask
    function automatic logic [31:0] md(input int s, input int op, input int sen, input int i);
        return {16'h0, 4'(i), 5'h0, 1'(sen), 2'(op), 4'(s)};
    endfunction
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        final_report;
    end
    initial begin
        seed = 32'hC355;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        aresetn = 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`RIC_REG_MODE, 34'h0);
        rd(`RIC_REG_THRESH, 34'h0);
        rd(`RIC_REG_SCALE, 34'h0);
        st(0, 0);
        rd(8'h18, {`RIC_RESP_DECERR, 32'h0});
        wr(8'h1C, 32'hFFFFFFFF, `RIC_RESP_DECERR);
        wr(`RIC_REG_STATUS, 32'h3, `RIC_RESP_OKAY);
        st(0, 0);
        for (k = 0; k < 12; k++) begin
            s = (k % 3 == 0) ? 2 : (k % 3 == 1) ? 7 : 6;
            sen = (k / 3) % 2;
            v = $random(seed);
            i = $random(seed) & 15;
            if (s == 6) wr(`RIC_REG_FLAGS, v, `RIC_RESP_OKAY);
            else io.put_val(s, 0, v);
            wr(`RIC_REG_MODE, md(s, 0, sen, i), `RIC_RESP_OKAY);
            st(1, v[i] == sen[0]);
        end
        for (k = 0; k < 24; k++) begin
            s = (k < 6) ? 1 : (k < 12) ? 3 : (k < 18) ? 4 : 8;
            op = k % 3;
            ch = $random(seed) & 7;
            v = ($random(seed) & 32'h7FFF) + 1;
            t = v + ($random(seed) % 2);
            e = (op == 0) ? v >= t : (op == 1) ? v == t : v <= t;
            if (s == 1) io.put_analog(ch, v[15:0]);
            else io.put_val(s, ch, v);
            wr(`RIC_REG_THRESH, t, `RIC_RESP_OKAY);
            wr(`RIC_REG_MODE, md(s, op, 0, ch), `RIC_RESP_OKAY);
            st(1, e);
        end
        wr(`RIC_REG_MODE, md(3, 3, 0, 0), `RIC_RESP_OKAY);
        st(1, 0);
        io.put_analog(5, 16'h0);
        io.put_analog(5, 16'h3333);
        wr(`RIC_REG_THRESH, 32'h14, `RIC_RESP_OKAY);
        wr(`RIC_REG_MODE, md(1, 2, 0, 5) | 32'h80, `RIC_RESP_OKAY);
        st(1, 0);
        io.put_analog(5, 16'h6667);
        st(1, 1);
        io.put_analog(5, 16'h6667);
        st(1, 0);
        wr(`RIC_REG_SCALE, 32'h000A0000, `RIC_RESP_OKAY);
        wr(`RIC_REG_THRESH, 32'h5, `RIC_RESP_OKAY);
        io.put_analog(0, 16'h7FFF);
        wr(`RIC_REG_MODE, md(1, 0, 0, 0) | 32'h100, `RIC_RESP_OKAY);
        st(1, 0);
        io.put_analog(0, 16'h8000);
        st(1, 1);
        wr(`RIC_REG_THRESH, 32'h3, `RIC_RESP_OKAY);
        wr(`RIC_REG_MODE, md(5, 2, 0, 0), `RIC_RESP_OKAY);
        st(1, 1);
        wr(`RIC_REG_MODE, md(5, 0, 0, 15), `RIC_RESP_OKAY);
        st(1, 0);
        wr(`RIC_REG_TRUN, 32'h8000, `RIC_RESP_OKAY);
        st(1, 0);
        repeat (30) @(posedge aclk);
        st(1, 1);
        wr(`RIC_REG_TRUN, 32'h0, `RIC_RESP_OKAY);
        st(1, 0);
        wr(`RIC_REG_MODE, 32'h9, `RIC_RESP_OKAY);
        st(0, 0);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`RIC_REG_MODE, 34'h0);
        st(0, 0);
        final_report;
    end
endmodule // testbench

// >>> verilog/ric_cond_eval.sv
// input-condition evaluator of one logic rule, with AXI4-Lite registers
// assumes analog, count, frequency and counter values come from aclk logic;
// discrete inputs and output readback are pins and are synchronised here
//
// Notes on behaviour
// - analog value mode compares present channel value
// - deviation is sample difference over full range
// - deviation true when above percent threshold
// - analog compares: greater-equal, equal, less-equal
// - scaling maps reading linearly to engineering units
// - discrete input true when level matches sense
// - counter input count compared with threshold
// - frequency input compared with threshold
// - sixteen timers hold elapsed time since start
// - timer threshold in 10 ms units
// - sixteen single-bit internal flags readable
// - flag mode true when flag equals sense
// - output readback true when state equals sense
// - eight internal counters compared with threshold
// - one-bit result goes to logic stage
// - default source is none, no condition
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`include "ric_map.svh"
module ric_cond_eval #(
    parameter logic [20:0] TICK_CYCLES = 21'(`RIC_TICK_CYCLES)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0][15:0] analog_value,
    input wire logic analog_sample,
    input wire logic [7:0][31:0] count_value,
    input wire logic [7:0][31:0] freq_value,
    input wire logic [7:0][31:0] counter_value,
    input wire logic [15:0] discrete_in_pin,
    input wire logic [15:0] dout_state_pin,
    output logic cond_result,
    output logic cond_active
);
    localparam ric_pkg::ric_top_st_t RST = '{
        awready: 1'b1, wready: 1'b1, arready: 1'b1,
        mode: `RIC_MODE_RST, thresh: `RIC_THRESH_RST, scale: `RIC_SCALE_RST,
        default: '0
    };

    ric_pkg::ric_top_st_t st_ff;
    ric_pkg::ric_top_st_t nxt_st;
    logic [15:0] din_sync;
    logic [15:0] do_sync;
    ric_pkg::ric_src_t src;
    logic [3:0] idx;
    logic sense;
    logic [15:0] raw;
    logic signed [49:0] s_raw;
    logic signed [49:0] s_prev;
    logic signed [49:0] s_min;
    logic signed [49:0] s_max;
    logic signed [49:0] s_thr;
    logic signed [49:0] s_full;
    logic signed [49:0] s_dev;
    logic signed [49:0] lhs;
    logic signed [49:0] rhs;
    logic hit;

    ric_tmr_if tif ();

    ric_sync2 u_din_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(discrete_in_pin),
        .sync_out(din_sync)
    );

    ric_sync2 u_do_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(dout_state_pin),
        .sync_out(do_sync)
    );

    ric_timer_bank #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timers (
        .aclk(aclk),
        .aresetn(aresetn),
        .tmr(tif.bank)
    );

    assign tif.run = st_ff.trun;

    function automatic logic cmp(
        input logic signed [49:0] a,
        input logic signed [49:0] b,
        input logic [1:0] op
    );
        unique case (ric_pkg::ric_op_t'(op))
            ric_pkg::ric_op_ge: cmp = (a >= b);
            ric_pkg::ric_op_eq: cmp = (a == b);
            ric_pkg::ric_op_le: cmp = (a <= b);
            default: cmp = 1'b0;
        endcase
    endfunction

    function automatic logic signed [49:0] uext(input logic [31:0] v);
        uext = $signed({18'h0, v});
    endfunction

    function automatic logic [31:0] wmerge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        wmerge = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                wmerge[b*8 +: 8] = data[b*8 +: 8];
            end
        end
    endfunction

    always_comb begin
        nxt_st = st_ff;
        // write path: address and data may arrive in either order
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.awaddr = s_axi_awaddr;
            nxt_st.aw_got = 1'b1;
            nxt_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.wdata = s_axi_wdata;
            nxt_st.wstrb = s_axi_wstrb;
            nxt_st.w_got = 1'b1;
            nxt_st.wready = 1'b0;
        end
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = `RIC_RESP_OKAY;
            unique case ({st_ff.awaddr[7:2], 2'b00})
                `RIC_REG_MODE:
                    nxt_st.mode = 16'(wmerge({16'h0, st_ff.mode}, st_ff.wdata, st_ff.wstrb));
                `RIC_REG_THRESH:
                    nxt_st.thresh = wmerge(st_ff.thresh, st_ff.wdata, st_ff.wstrb);
                `RIC_REG_SCALE:
                    nxt_st.scale = wmerge(st_ff.scale, st_ff.wdata, st_ff.wstrb);
                `RIC_REG_FLAGS:
                    nxt_st.flags = 16'(wmerge({16'h0, st_ff.flags}, st_ff.wdata,
                        st_ff.wstrb));
                `RIC_REG_TRUN:
                    nxt_st.trun = 16'(wmerge({16'h0, st_ff.trun}, st_ff.wdata,
                        st_ff.wstrb));
                `RIC_REG_STATUS: ;
                default: nxt_st.bresp = `RIC_RESP_DECERR;
            endcase
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
            nxt_st.awready = 1'b1;
            nxt_st.wready = 1'b1;
        end
        // read path: one read in flight, data sampled at the address edge
        if (s_axi_arvalid && st_ff.arready) begin
            nxt_st.arready = 1'b0;
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = `RIC_RESP_OKAY;
            nxt_st.rdata = 32'h0;
            unique case ({s_axi_araddr[7:2], 2'b00})
                `RIC_REG_MODE: nxt_st.rdata = {16'h0, st_ff.mode};
                `RIC_REG_THRESH: nxt_st.rdata = st_ff.thresh;
                `RIC_REG_SCALE: nxt_st.rdata = st_ff.scale;
                `RIC_REG_FLAGS: nxt_st.rdata = {16'h0, st_ff.flags};
                `RIC_REG_TRUN: nxt_st.rdata = {16'h0, st_ff.trun};
                `RIC_REG_STATUS: begin
                    nxt_st.rdata[`RIC_ST_RESULT] = st_ff.result;
                    nxt_st.rdata[`RIC_ST_ACTIVE] = st_ff.active;
                end
                default: nxt_st.rresp = `RIC_RESP_DECERR;
            endcase
        end
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
            nxt_st.arready = 1'b1;
        end
        // analog samples are held per strobe so deviation sees two real samples
        if (analog_sample) begin
            nxt_st.analog_prev = st_ff.analog_last;
            nxt_st.analog_last = analog_value;
        end
        // evaluation from registered configuration only
        src = ric_pkg::ric_src_t'(st_ff.mode[`RIC_F_SRC]);
        idx = st_ff.mode[`RIC_F_IDX];
        sense = st_ff.mode[`RIC_F_SENSE];
        raw = st_ff.analog_last[idx[2:0]];
        s_raw = uext({16'h0, raw});
        s_prev = uext({16'h0, st_ff.analog_prev[idx[2:0]]});
        s_min = 50'(signed'(st_ff.scale[`RIC_F_SMIN]));
        s_max = 50'(signed'(st_ff.scale[`RIC_F_SMAX]));
        s_thr = 50'(signed'(st_ff.thresh));
        s_full = uext({16'h0, `RIC_ANALOG_FULL});
        s_dev = (s_raw >= s_prev) ? s_raw - s_prev : s_prev - s_raw;
        lhs = s_raw;
        rhs = s_thr;
        hit = 1'b0;
        unique case (src)
            ric_pkg::no_source_selected: hit = 1'b0;
            ric_pkg::analog_in_source: begin
                if (st_ff.mode[`RIC_F_DEV]) begin
                    // |a-b|/full > t% rewritten without a divider
                    lhs = s_dev * `RIC_PCT;
                    rhs = uext(st_ff.thresh) * s_full;
                    hit = (lhs > rhs);
                end else if (st_ff.mode[`RIC_F_SCALE]) begin
                    // threshold mapped back onto the raw scale, no division
                    lhs = s_raw * (s_max - s_min);
                    rhs = (s_thr - s_min) * s_full;
                    hit = cmp(lhs, rhs, st_ff.mode[`RIC_F_OP]);
                end else begin
                    hit = cmp(s_raw, uext(st_ff.thresh), st_ff.mode[`RIC_F_OP]);
                end
            end
            ric_pkg::discrete_in_source: hit = (din_sync[idx] == sense);
            ric_pkg::count_in_source:
                hit = cmp(uext(count_value[idx[2:0]]), uext(st_ff.thresh),
                    st_ff.mode[`RIC_F_OP]);
            ric_pkg::freq_in_source:
                hit = cmp(uext(freq_value[idx[2:0]]), uext(st_ff.thresh),
                    st_ff.mode[`RIC_F_OP]);
            ric_pkg::timer_source:
                hit = cmp(uext(tif.elapsed[idx]), uext(st_ff.thresh),
                    st_ff.mode[`RIC_F_OP]);
            ric_pkg::internal_flag_source: hit = (st_ff.flags[idx] == sense);
            ric_pkg::dout_source: hit = (do_sync[idx] == sense);
            ric_pkg::counter_source:
                hit = cmp(uext(counter_value[idx[2:0]]), uext(st_ff.thresh),
                    st_ff.mode[`RIC_F_OP]);
            default: hit = 1'b0;
        endcase
        nxt_st.active = (src != ric_pkg::no_source_selected) && (src <= ric_pkg::counter_source);
        nxt_st.result = hit;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready = st_ff.wready;
    assign s_axi_bvalid = st_ff.bvalid;
    assign s_axi_bresp = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid = st_ff.rvalid;
    assign s_axi_rresp = st_ff.rresp;
    assign s_axi_rdata = st_ff.rdata;
    assign cond_result = st_ff.result;
    assign cond_active = st_ff.active;
endmodule // ric_cond_eval

// >>> verilog/ric_map.svh
// register map, field positions, reset values and timing counts
// assumes a 125 MHz aclk and byte addresses on an 8-bit AXI4-Lite address
`ifndef RIC_MAP_SVH
`define RIC_MAP_SVH
`define RIC_REG_MODE 8'h00
`define RIC_REG_THRESH 8'h04
`define RIC_REG_SCALE 8'h08
`define RIC_REG_FLAGS 8'h0C
`define RIC_REG_TRUN 8'h10
`define RIC_REG_STATUS 8'h14
`define RIC_F_SRC 3:0
`define RIC_F_OP 5:4
`define RIC_F_SENSE 6
`define RIC_F_DEV 7
`define RIC_F_SCALE 8
`define RIC_F_IDX 15:12
`define RIC_F_SMIN 15:0
`define RIC_F_SMAX 31:16
`define RIC_ST_RESULT 0
`define RIC_ST_ACTIVE 1
`define RIC_MODE_RST 16'h0000
`define RIC_THRESH_RST 32'h00000000
`define RIC_SCALE_RST 32'h00000000
`define RIC_RESP_OKAY 2'h0
`define RIC_RESP_DECERR 2'h3
`define RIC_ANALOG_FULL 16'hFFFF
`define RIC_PCT 50'h64
`define RIC_CLK_MHZ 125
`define RIC_TICK_MS 10
`define RIC_TICK_CYCLES (`RIC_TICK_MS * `RIC_CLK_MHZ * 1000)
`endif

// >>> verilog/ric_pkg.sv
// types shared by the condition evaluator and its helpers
// assumes the map header supplies all numbers
package ric_pkg;
    typedef enum logic [3:0] {
        no_source_selected = 4'b0000,
        analog_in_source = 4'b0001,
        discrete_in_source = 4'b0010,
        count_in_source = 4'b0011,
        freq_in_source = 4'b0100,
        timer_source = 4'b0101,
        internal_flag_source = 4'b0110,
        dout_source = 4'b0111,
        counter_source = 4'b1000
    } ric_src_t;
    typedef enum logic [1:0] {
        ric_op_ge = 2'b00,
        ric_op_eq = 2'b01,
        ric_op_le = 2'b10
    } ric_op_t;
    typedef struct packed {
        logic [15:0] meta;
        logic [15:0] sync;
    } ric_sync_st_t;
    typedef struct packed {
        logic [20:0] div;
        logic [15:0][31:0] elapsed;
    } ric_tmr_st_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] awaddr;
        logic aw_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_got;
        logic [15:0] mode;
        logic [31:0] thresh;
        logic [31:0] scale;
        logic [15:0] flags;
        logic [15:0] trun;
        logic [7:0][15:0] analog_last;
        logic [7:0][15:0] analog_prev;
        logic result;
        logic active;
    } ric_top_st_t;
endpackage

// >>> verilog/ric_sync2.sv
// two-flop synchroniser for a 16-bit group of pin levels
// assumes each bit is an independent slow level
`timescale 1ns/100ps
module ric_sync2 (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] pin_in,
    output logic [15:0] sync_out
);
    ric_pkg::ric_sync_st_t st_ff;
    ric_pkg::ric_sync_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.meta = pin_in;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.sync;
endmodule // ric_sync2

// >>> verilog/ric_timer_bank.sv
// sixteen elapsed-time timers counting in 10 ms ticks
// assumes run is a level: low clears a timer, high lets it count
`timescale 1ns/100ps
`include "ric_map.svh"
module ric_timer_bank #(
    parameter logic [20:0] TICK_CYCLES = 21'(`RIC_TICK_CYCLES)
) (
    input wire logic aclk,
    input wire logic aresetn,
    ric_tmr_if.bank tmr
);
    ric_pkg::ric_tmr_st_t st_ff;
    ric_pkg::ric_tmr_st_t nxt_st;
    logic tick;

    always_comb begin
        nxt_st = st_ff;
        tick = (st_ff.div == TICK_CYCLES - 21'h1);
        nxt_st.div = tick ? 21'h0 : st_ff.div + 21'h1;
        for (int i = 0; i < 16; i++) begin
            // saturate rather than wrap so a long wait never looks short
            if (!tmr.run[i]) begin
                nxt_st.elapsed[i] = 32'h0;
            end else if (tick && st_ff.elapsed[i] != 32'hFFFFFFFF) begin
                nxt_st.elapsed[i] = st_ff.elapsed[i] + 32'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tmr.elapsed = st_ff.elapsed;
endmodule // ric_timer_bank

// >>> verilog/ric_tmr_if.sv
// run controls out to the timer bank, elapsed values back
// assumes both ends share aclk
`timescale 1ns/100ps
interface ric_tmr_if;
    logic [15:0] run;
    logic [15:0][31:0] elapsed;
    modport ctl (output run, input elapsed);
    modport bank (input run, output elapsed);
endinterface
